// file: verilog/mem_support.sv
// Memory support bus controller with strap capture and EEPROM load
`timescale 1ns/1ps
`default_nettype none
`include "mem_support_defs.svh"
module mem_support (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [7:0] mem_data_low_in,
    output logic [7:0] mem_data_low_out,
    output logic [7:0] mem_data_low_oe,
    input wire logic [7:0] mem_data_high_in,
    output logic [7:0] mem_data_high_out,
    output logic [7:0] mem_data_high_oe,
    input wire logic [7:0] mem_addr_low_in,
    output logic [7:0] mem_addr_low_out,
    output logic [7:0] mem_addr_low_oe,
    output logic [6:0] mem_addr_high,
    output logic mem_read_strobe,
    output logic mem_write_strobe,
    output logic boot_rom_select,
    output logic ram_select_low,
    output logic ram_select_high,
    output logic eeprom_select,
    input wire logic serial_config_select,
    output logic coax_dcdc_enable_out
);
    // ----------------------------------------
    // Pin synchronisers and strap capture
    // ----------------------------------------
    logic [7:0] a_meta, a_sync, b_meta, b_sync, c_meta, c_sync;
    logic sel_meta, sel_sync;
    logic [7:0] cfg_a, cfg_b, cfg_c;

    // Not reset: they must keep sampling the straps during reset
    always_ff @(posedge clk) begin
        a_meta <= mem_data_low_in;
        a_sync <= a_meta;
        b_meta <= mem_data_high_in;
        b_sync <= b_meta;
        c_meta <= mem_addr_low_in;
        c_sync <= c_meta;
        sel_meta <= serial_config_select;
        sel_sync <= sel_meta;
    end

    // Last value seen before release is the strap setting
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_a <= a_sync;
            cfg_b <= b_sync;
            cfg_c <= c_sync;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            coax_dcdc_enable_out <= 1'b0;
        end else begin
            coax_dcdc_enable_out <= cfg_a[`CFG_THIN_BIT];
        end
    end

    // ----------------------------------------
    // EEPROM loader
    // ----------------------------------------
    eeprom_bus_if ee ();
    logic loading;

    assign ee.enable = sel_sync;
    assign ee.si = a_sync[1];
    assign ee.word_sel = araddr[4:2];
    assign loading = !ee.done;

    eeprom_loader loader (
        .clk(clk),
        .sys_rst(sys_rst),
        .ee(ee.loader)
    );

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    logic aw_held, w_held, wr_fire, wr_ok, go;
    logic [7:0] aw_addr;
    logic [31:0] w_data, wmask;
    logic [3:0] w_strb;
    logic [15:0] addr, wr_data, mem_rdata;
    logic rom_sel, byte_mode, compat, is_wr;
    logic [31:0] next_rdata;
    logic rd_ok;
    mem_support_pkg::mem_state_type state;
    logic [2:0] cnt;
    logic [6:0] next_addr_high;

    assign awready = !aw_held;
    assign wready = !w_held;
    assign arready = !rvalid;
    assign wr_fire = aw_held && w_held && !bvalid;
    assign go = wr_fire && aw_addr == `REG_CTRL && w_strb[0] &&
                state == mem_support_pkg::MEM_IDLE && !loading &&
                (w_data[`CTRL_RD] || w_data[`CTRL_WR]);

    genvar i;
    for (i = 0; i < 4; i++) begin : g_lane
        assign wmask[8*i +: 8] = {8{w_strb[i]}};
    end

    always_comb begin
        case (aw_addr)
            `REG_CFG, `REG_ADDR, `REG_WDATA, `REG_CTRL,
            `REG_STATUS, `REG_RDATA: wr_ok = 1'b1;
            default: wr_ok = (aw_addr & `PROM_MASK) == `REG_PROM_BASE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Address and data are frozen while a memory cycle runs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            addr <= 16'h0000;
            wr_data <= 16'h0000;
            rom_sel <= 1'b0;
            byte_mode <= 1'b0;
            compat <= 1'b0;
        end else if (wr_fire && state == mem_support_pkg::MEM_IDLE) begin
            if (aw_addr == `REG_ADDR) begin
                addr <= (addr & ~wmask[15:0]) | (w_data[15:0] & wmask[15:0]);
            end
            if (aw_addr == `REG_WDATA) begin
                wr_data <= (wr_data & ~wmask[15:0]) |
                           (w_data[15:0] & wmask[15:0]);
            end
            if (aw_addr == `REG_CTRL && w_strb[0]) begin
                rom_sel <= w_data[`CTRL_ROM];
                byte_mode <= w_data[`CTRL_BYTE];
                compat <= w_data[`CTRL_COMPAT];
            end
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        rd_ok = 1'b1;
        case (araddr)
            `REG_CFG: next_rdata = {8'h00, cfg_c, cfg_b, cfg_a};
            `REG_ADDR: next_rdata = {16'h0000, addr};
            `REG_WDATA: next_rdata = {16'h0000, wr_data};
            `REG_CTRL: next_rdata = {27'h0, compat, byte_mode, rom_sel, 2'h0};
            `REG_STATUS: next_rdata = {29'h0, sel_sync, ee.done,
                                       state != mem_support_pkg::MEM_IDLE};
            `REG_RDATA: next_rdata = {16'h0000, mem_rdata};
            default: begin
                if ((araddr & `PROM_MASK) == `REG_PROM_BASE) begin
                    next_rdata = {16'h0000, ee.done ? ee.word : 16'h0000};
                end else begin
                    rd_ok = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Memory cycle sequencer
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= mem_support_pkg::MEM_IDLE;
            cnt <= 3'h0;
            is_wr <= 1'b0;
        end else begin
            case (state)
                mem_support_pkg::MEM_IDLE: begin
                    cnt <= 3'h0;
                    if (go) begin
                        is_wr <= w_data[`CTRL_WR];
                        state <= mem_support_pkg::MEM_SETUP;
                    end
                end
                mem_support_pkg::MEM_SETUP: begin
                    state <= mem_support_pkg::MEM_STROBE;
                end
                mem_support_pkg::MEM_STROBE: begin
                    if (cnt == 3'(`MEM_STROBE_CYC - 1)) begin
                        state <= mem_support_pkg::MEM_HOLD;
                    end else begin
                        cnt <= cnt + 3'h1;
                    end
                end
                mem_support_pkg::MEM_HOLD: begin
                    state <= mem_support_pkg::MEM_IDLE;
                end
                default: begin
                    state <= mem_support_pkg::MEM_IDLE;
                end
            endcase
        end
    end

    // Pins lag the state by one edge and the sampler by two more,
    // so HOLD still sees data taken inside the strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mem_rdata <= 16'h0000;
        end else if (state == mem_support_pkg::MEM_HOLD && !is_wr) begin
            mem_rdata <= (byte_mode || rom_sel) ? {8'h00, a_sync}
                                                : {b_sync, a_sync};
        end
    end

    always_comb begin
        next_addr_high = addr[15:9];
        if (byte_mode) begin
            if (compat) begin
                next_addr_high[`A0_COMPAT_IDX] = addr[0];
            end else begin
                next_addr_high[`A0_NATIVE_IDX] = addr[0];
            end
        end
    end

    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    logic active, wr_drive;
    assign active = state != mem_support_pkg::MEM_IDLE;
    assign wr_drive = active && is_wr;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mem_data_low_out <= 8'h00;
            mem_data_low_oe <= 8'h00;
            mem_data_high_out <= 8'h00;
            mem_data_high_oe <= 8'h00;
            mem_addr_low_out <= 8'h00;
            mem_addr_low_oe <= 8'h00;
            mem_addr_high <= 7'h00;
            mem_read_strobe <= 1'b0;
            mem_write_strobe <= 1'b0;
            boot_rom_select <= 1'b0;
            ram_select_low <= 1'b0;
            ram_select_high <= 1'b0;
            eeprom_select <= 1'b0;
        end else begin
            if (loading) begin
                mem_data_low_out <= {5'h00, ee.sk, 1'b0, ee.so};
                mem_data_low_oe <= `EE_PIN_OE;
            end else begin
                mem_data_low_out <= wr_data[7:0];
                mem_data_low_oe <= {8{wr_drive}};
            end
            mem_data_high_out <= wr_data[15:8];
            mem_data_high_oe <= {8{wr_drive && !byte_mode && !rom_sel}};
            mem_addr_low_out <= addr[8:1];
            mem_addr_low_oe <= 8'hFF;
            mem_addr_high <= next_addr_high;
            mem_read_strobe <= state == mem_support_pkg::MEM_STROBE &&
                               !is_wr;
            mem_write_strobe <= state == mem_support_pkg::MEM_STROBE &&
                                is_wr;
            boot_rom_select <= active && rom_sel;
            ram_select_low <= active && !rom_sel;
            ram_select_high <= active && !rom_sel && !byte_mode;
            eeprom_select <= ee.cs;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_strap_release: assert property (
        $fell(sys_rst) |-> mem_data_low_oe == 8'h00 &&
            mem_data_high_oe == 8'h00 && mem_addr_low_oe == 8'h00)
        else $error("strap pins driven during reset");
    a_cfg_a_load: assert property (
        $fell(sys_rst) |-> cfg_a == $past(a_sync) ##1 $stable(cfg_a))
        else $error("configuration A not taken from straps");
    a_cfg_bc_load: assert property (
        $fell(sys_rst) |-> cfg_b == $past(b_sync) && cfg_c == $past(c_sync))
        else $error("configuration B or C not taken from straps");
    a_thin_enable: assert property (
        ##1 $stable(cfg_a) [*2] |-> coax_dcdc_enable_out == cfg_a[`CFG_THIN_BIT])
        else $error("DC-DC enable does not follow thin selection");
    a_addr_drive: assert property (
        mem_read_strobe || mem_write_strobe |->
            mem_addr_low_out == addr[8:1] && mem_addr_low_oe == 8'hFF)
        else $error("address bus not driven during strobe");
    a_byte_a0: assert property (
        (mem_read_strobe || mem_write_strobe) && byte_mode |->
            mem_addr_high[compat ? `A0_COMPAT_IDX : `A0_NATIVE_IDX] == addr[0])
        else $error("byte address bit on wrong line");
    a_read_capture: assert property (
        state == mem_support_pkg::MEM_HOLD && !is_wr |=>
            mem_rdata[7:0] == $past(a_sync))
        else $error("read data not captured");
    a_write_drive: assert property (
        mem_write_strobe |-> mem_data_low_oe == 8'hFF &&
            mem_data_low_out == wr_data[7:0])
        else $error("write strobe without driven data");
    a_rom_select: assert property (
        boot_rom_select |-> !ram_select_low && !ram_select_high)
        else $error("boot ROM and RAM selected together");
    a_byte_lanes: assert property (
        ram_select_high |-> ram_select_low && !byte_mode)
        else $error("upper RAM selected on byte memory");
    a_ee_select: assert property (
        eeprom_select |-> !ram_select_low && !boot_rom_select &&
            mem_data_low_oe == `EE_PIN_OE)
        else $error("EEPROM select clashes with memory access");
    c_ram_read: cover property (mem_read_strobe && ram_select_high);
    c_ram_write: cover property (mem_write_strobe ##1 !mem_write_strobe);
    c_rom_read: cover property (boot_rom_select && mem_read_strobe);
endmodule
`default_nettype wire

// file: verilog/mem_support_defs.svh
// Constants of the memory support bus and strap loader
//
// Contract
// - Thin coax configured drives DC-DC enable high
// - Low data byte carries memory and PROM data
// - Reset loads configuration A from low data
// - Reset loads configuration B from high data
// - Reset loads configuration C from address pins
// - Reset release reads serial EEPROM into registers
// - Loaded EEPROM words appear in PROM space
// - After load, EEPROM lines revert to data
// - After reset drive word address bits 1-15
// - Byte-wide memory puts A0 on A13/A15
// - Read strobe fetches RAM data, captured internally
// - Write strobe while driving write data
// - Boot ROM select during boot PROM access
// - EEPROM load only when select input high
// - Low/high RAM selects per data byte
// - EEPROM select strobes EEPROM data onto bus
`ifndef MEM_SUPPORT_DEFS_SVH
`define MEM_SUPPORT_DEFS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_NS 50
`define MEM_STROBE_NS 200
`define MEM_STROBE_CYC ((`MEM_STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define EE_HALF_NS 500
`define EE_HALF_CYC ((`EE_HALF_NS + `CLK_NS - 1) / `CLK_NS)

// ----------------------------------------
// EEPROM read sequence
// ----------------------------------------
`define EE_WORDS 8
`define EE_CMD_BITS 9
`define EE_DATA_BITS 16
`define EE_READ_CMD 3'h6
`define EE_PIN_OE 8'h05

// ----------------------------------------
// Register offsets and fields
// ----------------------------------------
`define REG_CFG 8'h00
`define REG_ADDR 8'h04
`define REG_WDATA 8'h08
`define REG_CTRL 8'h0C
`define REG_STATUS 8'h10
`define REG_RDATA 8'h14
`define REG_PROM_BASE 8'h40
`define PROM_MASK 8'hE3
`define CTRL_RD 0
`define CTRL_WR 1
`define CTRL_ROM 2
`define CTRL_BYTE 3
`define CTRL_COMPAT 4
`define CFG_THIN_BIT 0
`define A0_COMPAT_IDX 4
`define A0_NATIVE_IDX 6
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: verilog/mem_support_pkg.sv
// Types shared by the memory support bus modules
`default_nettype none
package mem_support_pkg;
    typedef enum logic [1:0] {
        MEM_IDLE = 2'h0,
        MEM_SETUP = 2'h1,
        MEM_STROBE = 2'h3,
        MEM_HOLD = 2'h2
    } mem_state_type;
    typedef enum logic [2:0] {
        EE_IDLE = 3'h0,
        EE_CMD = 3'h1,
        EE_DATA = 3'h3,
        EE_GAP = 3'h2,
        EE_DONE = 3'h6
    } ee_state_type;
endpackage
`default_nettype wire

// file: verilog/eeprom_bus_if.sv
// Link between the bus controller and the EEPROM loader
`timescale 1ns/1ps
`default_nettype none
interface eeprom_bus_if;
    logic enable;
    logic si;
    logic [2:0] word_sel;
    logic done;
    logic sk;
    logic so;
    logic cs;
    logic [15:0] word;
    modport loader(input enable, si, word_sel, output done, sk, so, cs, word);
    modport owner(output enable, si, word_sel, input done, sk, so, cs, word);
endinterface
`default_nettype wire

// file: verilog/eeprom_loader.sv
// Serial EEPROM reader that fills the station PROM image
`timescale 1ns/1ps
`default_nettype none
`include "mem_support_defs.svh"
module eeprom_loader (
    input wire logic clk,
    input wire logic sys_rst,
    eeprom_bus_if.loader ee
);
    mem_support_pkg::ee_state_type state;
    logic [4:0] half_cnt;
    logic phase;
    logic [4:0] bit_cnt;
    logic [2:0] word_idx;
    logic [15:0] shreg;
    logic [8:0] cmd;
    logic tick;
    logic bit_end;
    logic [15:0] rom [0:`EE_WORDS-1];

    assign cmd = {`EE_READ_CMD, 3'h0, word_idx};
    assign tick = half_cnt == 5'(`EE_HALF_CYC - 1);
    assign bit_end = tick && phase;
    assign ee.word = rom[ee.word_sel];

    // Shift clock divider, idle outside the read
    always_ff @(posedge clk) begin
        if (sys_rst || state == mem_support_pkg::EE_IDLE ||
            state == mem_support_pkg::EE_DONE) begin
            half_cnt <= 5'h00;
            phase <= 1'b0;
        end else if (tick) begin
            half_cnt <= 5'h00;
            phase <= !phase;
        end else begin
            half_cnt <= half_cnt + 5'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= mem_support_pkg::EE_IDLE;
            bit_cnt <= 5'h00;
            word_idx <= 3'h0;
            shreg <= 16'h0000;
        end else begin
            case (state)
                mem_support_pkg::EE_IDLE: begin
                    if (ee.enable) begin
                        state <= mem_support_pkg::EE_CMD;
                    end else begin
                        state <= mem_support_pkg::EE_DONE;
                    end
                end
                mem_support_pkg::EE_CMD: begin
                    if (bit_end) begin
                        if (bit_cnt == 5'(`EE_CMD_BITS - 1)) begin
                            bit_cnt <= 5'h00;
                            state <= mem_support_pkg::EE_DATA;
                        end else begin
                            bit_cnt <= bit_cnt + 5'h01;
                        end
                    end
                end
                mem_support_pkg::EE_DATA: begin
                    // Sampled late in the high half to cover access time
                    if (bit_end) begin
                        shreg <= {shreg[14:0], ee.si};
                        if (bit_cnt == 5'(`EE_DATA_BITS - 1)) begin
                            bit_cnt <= 5'h00;
                            state <= mem_support_pkg::EE_GAP;
                        end else begin
                            bit_cnt <= bit_cnt + 5'h01;
                        end
                    end
                end
                mem_support_pkg::EE_GAP: begin
                    if (bit_end) begin
                        if (word_idx == 3'(`EE_WORDS - 1)) begin
                            state <= mem_support_pkg::EE_DONE;
                        end else begin
                            word_idx <= word_idx + 3'h1;
                            state <= mem_support_pkg::EE_CMD;
                        end
                    end
                end
                mem_support_pkg::EE_DONE: begin
                    state <= mem_support_pkg::EE_DONE;
                end
                default: begin
                    state <= mem_support_pkg::EE_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (state == mem_support_pkg::EE_DATA && bit_end &&
            bit_cnt == 5'(`EE_DATA_BITS - 1)) begin
            rom[word_idx] <= {shreg[14:0], ee.si};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ee.cs <= 1'b0;
            ee.sk <= 1'b0;
            ee.so <= 1'b0;
            ee.done <= 1'b0;
        end else begin
            ee.cs <= state == mem_support_pkg::EE_CMD ||
                     state == mem_support_pkg::EE_DATA;
            ee.sk <= phase && (state == mem_support_pkg::EE_CMD ||
                               state == mem_support_pkg::EE_DATA);
            ee.so <= state == mem_support_pkg::EE_CMD &&
                     cmd[4'(`EE_CMD_BITS - 1) - bit_cnt[3:0]];
            ee.done <= state == mem_support_pkg::EE_DONE;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_load_gate: assert property (
        state == mem_support_pkg::EE_IDLE && !ee.enable
        |=> state == mem_support_pkg::EE_DONE ##1 ee.done && !ee.cs)
        else $error("EEPROM read started without select");
    a_pins_return: assert property (
        ee.done |-> !ee.cs && !ee.sk && !ee.so && $past(ee.done, 1) ||
                    !$past(ee.cs))
        else $error("EEPROM lines active after load");
    a_cmd_start: assert property (
        $rose(ee.cs) |-> ee.so && !ee.sk)
        else $error("read command must open with start bit");
    c_load_done: cover property ($rose(ee.done) && ee.enable);
endmodule
`default_nettype wire

// file: testbench/mem_far_side.sv
// Far-side model: strap pull-ups and a small external RAM
`timescale 1ns/1ps
`default_nettype none
module mem_far_side #(parameter logic [7:0] PA = 8'h00, PB = 8'h00,
    PC = 8'h00) (
    input wire logic [7:0] mem_data_low_out, mem_data_low_oe,
    input wire logic [7:0] mem_data_high_out, mem_data_high_oe,
    input wire logic [7:0] mem_addr_low_out, mem_addr_low_oe,
    input wire logic mem_read_strobe, mem_write_strobe,
    input wire logic ram_select_low, ram_select_high,
    input wire logic boot_rom_select, eeprom_select,
    output logic [7:0] mem_data_low_in, mem_data_high_in, mem_addr_low_in
);
    logic [15:0] ram [16];
    logic [8:0] ee_c = 9'h000;
    logic [4:0] ee_n = 5'h00;
    logic ee_q = 1'b0;
    wire logic rom_rd = mem_read_strobe & boot_rom_select;
    wire logic ee_sk = mem_data_low_out[2] & mem_data_low_oe[2];
    // Word pattern {2, addr, 1, ~addr}, only after start bit and read code
    wire logic [15:0] ee_w = ee_c[8:6] == 3'h6 ?
        {2'h2, ee_c[5:0], 2'h1, ~ee_c[5:0]} : 16'h0000;
    // Serial EEPROM: 9 command bits in, then one data bit per shift edge
    always @(posedge ee_sk or negedge eeprom_select) begin
        if (!eeprom_select) begin
            ee_n <= 5'h00;
        end else begin
            if (ee_n < 5'h09) ee_c <= {ee_c[7:0], mem_data_low_out[0]};
            ee_q <= ee_n > 5'h08 && ee_n < 5'h19 && ee_w[5'h18 - ee_n];
            ee_n <= ee_n + 5'h01;
        end
    end
    wire logic [3:0] ix = mem_addr_low_out[3:0];
    wire logic rl = mem_read_strobe & ram_select_low;
    wire logic rh = mem_read_strobe & ram_select_high;
    // Undriven pins carry RAM, ROM or EEPROM data when selected, else the board's pull-up pattern
    assign mem_data_low_in = (mem_data_low_out & mem_data_low_oe) |
        (~mem_data_low_oe & (rl ? ram[ix][7:0] : rom_rd ? {4'hB, ix} :
        eeprom_select ? {6'h00, ee_q, 1'b0} : PA));
    assign mem_data_high_in = (mem_data_high_out & mem_data_high_oe) |
        (~mem_data_high_oe & (rh ? ram[ix][15:8] : PB));
    assign mem_addr_low_in = (mem_addr_low_out & mem_addr_low_oe) |
        (~mem_addr_low_oe & PC);
    always @(posedge mem_write_strobe) begin
        if (ram_select_low) ram[ix][7:0] <= mem_data_low_out;
        if (ram_select_high) ram[ix][15:8] <= mem_data_high_out;
    end
endmodule
`default_nettype wire

// file: testbench/mem_support_tb.sv
// Self-checking bench for the memory support bus controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin n_fail++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module mem_support_tb;
    localparam logic [7:0] SA = 8'hA5, SB = 8'h3C, SC = 8'h81;
    logic clk = 0, sys_rst = 1, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, serial_config_select = 0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, mem_read_strobe, ra, rw;
    logic mem_write_strobe, boot_rom_select, ram_select_low, ram_select_high;
    logic eeprom_select, coax_dcdc_enable_out;
    logic [7:0] mem_data_low_in, mem_data_low_out, mem_data_low_oe;
    logic [7:0] mem_data_high_in, mem_data_high_out, mem_data_high_oe;
    logic [7:0] mem_addr_low_in, mem_addr_low_out, mem_addr_low_oe;
    logic [6:0] mem_addr_high;
    logic [15:0] row_a [3] = '{16'h0002, 16'h001C, 16'h0010};
    logic [15:0] row_d [3] = '{16'h1234, 16'hA5C3, 16'hFFFF};
    int n_fail = 0, checks_done = 0, i, j, k;
    logic ee_seen = 0;
    logic [15:0] ew;
    always #25 clk = ~clk;
    always @(posedge clk) if (eeprom_select) ee_seen <= 1'b1;
    mem_support mem_support_i(.*);
    mem_far_side #(.PA(SA), .PB(SB), .PC(SC)) mem_far_side_i(.*);
    task give_verdict();
        if (n_fail == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) begin awaddr <= a; wdata <= d; awvalid <= 1'b1;
            wvalid <= 1'b1; bready <= 1'b1; end
        for (k = 0; k < 20; k++) begin
            @(negedge clk) {ra, rw, r[0]} = {awready, wready, bvalid};
            @(posedge clk);
            if (ra) awvalid <= 1'b0;
            if (rw) wvalid <= 1'b0;
            if (r[0]) begin bready <= 1'b0; break; end
        end
        if (k == 20) begin n_fail++; give_verdict(); end
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk) begin araddr <= a; arvalid <= 1'b1; rready <= 1'b1; end
        for (k = 0; k < 20; k++) begin
            @(negedge clk) {ra, rw, q, r} = {arready, rvalid, rdata, rresp};
            @(posedge clk);
            if (ra) arvalid <= 1'b0;
            if (rw) begin rready <= 1'b0; break; end
        end
        if (k == 20) begin n_fail++; give_verdict(); end
    endtask
    task mop(input logic [15:0] a, input logic [15:0] d, input logic [7:0] c);
        wr(8'h04, {16'h0, a});
        wr(8'h08, {16'h0, d});
        wr(8'h0C, {24'h0, c});
        for (i = 0; i < 20; i++) begin rd(8'h10); if (!q[0]) break; end
        if (i == 20) begin n_fail++; give_verdict(); end
    endtask
    task wait_load();
        for (j = 0; j < 2000; j++) begin rd(8'h10); if (q[1]) break; end
        if (j == 2000) begin n_fail++; give_verdict(); end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        @(negedge clk) `CHK("oe", 24'h0, {mem_data_low_oe, mem_data_high_oe,
            mem_addr_low_oe})
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        wait_load();
        `CHK("ee_cs", 1'b0, ee_seen)
        rd(8'h00);
        `CHK("cfg", {8'h0, SC, SB, SA}, q)
        `CHK("coax", SA[0], coax_dcdc_enable_out)
        for (j = 0; j < 3; j++) begin
            mop(row_a[j], row_d[j], 8'h02);
            mop(row_a[j], 16'h0, 8'h01);
            rd(8'h14);
            `CHK("ram", {16'h0, row_d[j]}, q)
        end
        mop(16'h0006, 16'h0, 8'h05);
        rd(8'h14);
        `CHK("rom", 32'h0000_00B3, q)
        rd(8'h0C);
        `CHK("ctrl", 32'h0000_0004, q)
        // Byte-wide memory: A0 moves to a high address line
        for (j = 0; j < 2; j++) begin
            wr(8'h04, 32'h1);
            wr(8'h0C, j ? 32'h1A : 32'h0A);
            for (i = 0; i < 20 && !mem_write_strobe; i++) @(negedge clk);
            if (i == 20) begin n_fail++; give_verdict(); end
            `CHK("a0", 1'b1, mem_addr_high[j ? 4 : 6])
            for (i = 0; i < 20 && mem_write_strobe; i++) @(negedge clk);
        end
        rd(8'hF0);
        `CHK("resp", 2'h2, r)
        // Second reset, now with the serial load selected
        sys_rst <= 1'b1;
        serial_config_select <= 1'b1;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        wait_load();
        `CHK("ee_cs", 1'b1, ee_seen)
        `CHK("ee_oe", 8'h00, mem_data_low_oe)
        for (j = 0; j < 8; j++) begin
            rd(8'(8'h40 + 4 * j));
            ew = {2'h2, 6'(j), 2'h1, ~6'(j)};
            `CHK("prom", {16'h0, ew}, q)
        end
        give_verdict();
    end
endmodule
`default_nettype wire
